// ===== src/uap_defines.vh
// Constants for the upper address port: register offsets, reset values, port width.
// Included by the port module; holds definitions only.
`ifndef UAP_DEFINES_VH
`define UAP_DEFINES_VH
`define UAP_NPINS          4
`define UAP_OFF_FUNC       4'h1
`define UAP_OFF_DIR        4'h3
`define UAP_OFF_OUT        4'h5
`define UAP_OFF_LEVEL      4'h7
`define UAP_OFF_CTRL       4'h8
`define UAP_OFF_STATUS     4'h9
`define UAP_RST_FUNC       4'hf
`define UAP_RST_DIR        4'hf
`define UAP_RST_OUT        4'h0
`define UAP_RST_ADDR       4'hf
`define UAP_PAGE_ZERO      4'h0
`define UAP_CTRL_VARIANT   0
`define UAP_ST_PRESET      0
`define UAP_ST_FETCH       1
`define UAP_ST_FLOAT       2
`endif

// ===== src/uap_port.v
// Upper address port: four pins, each general I/O or an upper address line.
// Assumes an Avalon-MM master on i_clk, a core bus controller giving access
// strobes, and an external pad that resolves the pin from output and enable.
//
// Operation
// - Reset forces address role, pin weakly high
// - Config byte fetch drives all ones strongly
// - All ones held until I/O or new address
// - Address pins float in idle, powerdown, standby, hold
// - I/O pins unchanged in low-power and hold
// - Nonextended access drives output value as page
// - Register file internal; other nonextended accesses off-chip
// - Second variant forces nonextended page to zero
// - Extended access drives upper four address bits
// - Register file and windowed registers map every page
// - Extended accesses reach locations under mapped areas
// - Last data address held between bus accesses
// - Powerdown disconnects address pin input buffers
// - Direction clear push-pull; set open-drain; function address
// - Level sense returns sampled pin levels, reading zero on address pins in powerdown
// - Direction set, output one: both drivers off
`timescale 1ns/100ps
`include "uap_defines.vh"
module uap_port #(
  parameter NPINS = `UAP_NPINS
) (
  input  wire             i_clk,
  input  wire             i_resetn,
  // Avalon-MM slave
  input  wire [3:0]       avs_address,
  input  wire             avs_read,
  input  wire             avs_write,
  input  wire [31:0]      avs_writedata,
  input  wire [3:0]       avs_byteenable,
  output reg  [31:0]      avs_readdata,
  output wire             avs_waitrequest,
  // Core bus controller side
  input  wire             i_cfg_fetch,
  input  wire             i_code_fetch,
  input  wire [NPINS-1:0] i_code_page,
  input  wire             i_data_access,
  input  wire             i_data_ext,
  input  wire [NPINS-1:0] i_data_page,
  input  wire             i_data_regfile,
  input  wire             i_idle,
  input  wire             i_powerdown,
  input  wire             i_standby,
  input  wire             i_hold,
  output wire             o_access_internal,
  output wire             o_access_offchip,
  output wire [NPINS-1:0] o_access_page,
  // Pins
  input  wire [NPINS-1:0] i_pin,
  output reg  [NPINS-1:0] o_pin,
  output reg  [NPINS-1:0] o_pin_oe,
  output wire [NPINS-1:0] o_pin_weak_pullup,
  output wire [NPINS-1:0] o_pin_inbuf_en
);

  reg  [NPINS-1:0] pin_function_select_q;
  reg  [NPINS-1:0] pin_direction_ctl_q;
  reg  [NPINS-1:0] pin_output_value_q;
  reg  [NPINS-1:0] func_live_q;
  reg  [NPINS-1:0] data_addr_q;
  reg  [NPINS-1:0] sync1_q;
  reg  [NPINS-1:0] sync2_q;
  reg              variant_q;
  reg              fetch_seen_q;
  reg              out_valid_q;
  reg              rd_pend_q;
  reg  [NPINS-1:0] pin_d;
  reg  [NPINS-1:0] oe_d;
  wire [NPINS-1:0] addr_src;
  wire [NPINS-1:0] nonext_page;
  wire             float_addr;
  wire             wr_lo;
  integer          k;

  // Byte-lane write of the low nibble
  function [NPINS-1:0] merge_lo;
    input [NPINS-1:0] old_v;
    input [31:0]      wd;
    input [3:0]       be;
    begin
      merge_lo = be[0] ? wd[NPINS-1:0] : old_v;
    end
  endfunction

  // Reads take one wait cycle; writes finish at once
  assign avs_waitrequest = avs_read & ~rd_pend_q;
  assign wr_lo = avs_write;

  // Software ordering of configuration writes is the master's job
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pin_function_select_q <= `UAP_RST_FUNC;
      pin_direction_ctl_q   <= `UAP_RST_DIR;
      pin_output_value_q    <= `UAP_RST_OUT;
      variant_q             <= 1'b0;
    end else if (wr_lo) begin
      case (avs_address)
        `UAP_OFF_FUNC: pin_function_select_q <=
                         merge_lo(pin_function_select_q, avs_writedata, avs_byteenable);
        `UAP_OFF_DIR:  pin_direction_ctl_q <=
                         merge_lo(pin_direction_ctl_q, avs_writedata, avs_byteenable);
        `UAP_OFF_OUT:  pin_output_value_q <=
                         merge_lo(pin_output_value_q, avs_writedata, avs_byteenable);
        `UAP_OFF_CTRL: begin
          if (avs_byteenable[0])
            variant_q <= avs_writedata[`UAP_CTRL_VARIANT];
        end
        default: ;
      endcase
    end
  end

  // Mux select is retimed so a change lands cleanly on the next edge
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn)
      func_live_q <= `UAP_RST_FUNC;
    else
      func_live_q <= pin_function_select_q;
  end

  // Page for nonextended data accesses
  assign nonext_page = variant_q ? `UAP_PAGE_ZERO : pin_output_value_q;

  // Data address latch keeps the last value between accesses
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      data_addr_q  <= `UAP_RST_ADDR;
      fetch_seen_q <= 1'b0;
      out_valid_q  <= 1'b0;
    end else begin
      if (i_cfg_fetch) begin
        data_addr_q  <= {NPINS{1'b1}};
        fetch_seen_q <= 1'b1;
      end else if (i_data_access && !(i_data_regfile && !i_data_ext)) begin
        if (i_data_ext)
          data_addr_q <= i_data_page;
        else
          data_addr_q <= nonext_page;
      end
      if (i_cfg_fetch || fetch_seen_q)
        out_valid_q <= 1'b1;
    end
  end

  // Code fetch uses the fetch page counter, otherwise the data latch
  assign addr_src = i_code_fetch ? i_code_page : data_addr_q;

  // Nonextended register file and windowed register accesses stay on chip in any page; extended ones go off-chip
  assign o_access_internal = i_data_access & i_data_regfile & ~i_data_ext;
  assign o_access_offchip  = i_data_access & ~o_access_internal;
  assign o_access_page     = i_data_ext ? i_data_page : nonext_page;

  assign float_addr = i_idle | i_powerdown | i_standby | i_hold;

  // Pin driver: address pins push-pull after the first config fetch unless floated, I/O per direction
  always @* begin
    pin_d = {NPINS{1'b0}};
    oe_d  = {NPINS{1'b0}};
    for (k = 0; k < NPINS; k = k + 1) begin
      if (func_live_q[k]) begin
        pin_d[k] = addr_src[k];
        oe_d[k]  = out_valid_q & ~float_addr;
      end else if (!pin_direction_ctl_q[k]) begin
        pin_d[k] = pin_output_value_q[k];
        oe_d[k]  = 1'b1;
      end else begin
        pin_d[k] = 1'b0;
        oe_d[k]  = ~pin_output_value_q[k];
      end
    end
  end

  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_pin    <= {NPINS{1'b0}};
      o_pin_oe <= {NPINS{1'b0}};
    end else begin
      o_pin    <= pin_d;
      o_pin_oe <= oe_d;
    end
  end

  // Weak pull-up only while reset holds
  assign o_pin_weak_pullup = {NPINS{~i_resetn}};
  assign o_pin_inbuf_en = ~(func_live_q & {NPINS{i_powerdown}});

  // Pin level sampler, two flops
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sync1_q <= {NPINS{1'b0}};
      sync2_q <= {NPINS{1'b0}};
    end else begin
      sync1_q <= i_pin;
      sync2_q <= sync1_q;
    end
  end

  // Read path
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rd_pend_q    <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      rd_pend_q <= avs_read & ~rd_pend_q;
      if (avs_read && !rd_pend_q) begin
        case (avs_address)
          `UAP_OFF_FUNC:   avs_readdata <= {28'h0, pin_function_select_q};
          `UAP_OFF_DIR:    avs_readdata <= {28'h0, pin_direction_ctl_q};
          `UAP_OFF_OUT:    avs_readdata <= {28'h0, pin_output_value_q};
          `UAP_OFF_LEVEL:  avs_readdata <= {28'h0, sync2_q & o_pin_inbuf_en};
          `UAP_OFF_CTRL:   avs_readdata <= {31'h0, variant_q};
          `UAP_OFF_STATUS: avs_readdata <= {29'h0, float_addr, fetch_seen_q, 1'b0};
          default:         avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule // uap_port

// ===== dv/uap_props.sv
// Checker for the upper address port, bound onto its top-level ports.
// Assumes register writes use byteenable lane 0.
`timescale 1ns/100ps
`include "uap_defines.vh"
module uap_props #(parameter NPINS = `UAP_NPINS) (
  input wire             i_clk,
  input wire             i_resetn,
  input wire             avs_write,
  input wire             i_cfg_fetch,
  input wire             i_data_access,
  input wire             i_data_ext,
  input wire             i_data_regfile,
  input wire             i_idle,
  input wire             i_powerdown,
  input wire             i_standby,
  input wire             i_hold,
  input wire             o_access_internal,
  input wire             o_access_offchip,
  input wire [3:0]       avs_address,
  input wire [3:0]       avs_byteenable,
  input wire [31:0]      avs_writedata,
  input wire [NPINS-1:0] i_data_page,
  input wire [NPINS-1:0] o_access_page,
  input wire [NPINS-1:0] o_pin,
  input wire [NPINS-1:0] o_pin_oe,
  input wire [NPINS-1:0] o_pin_weak_pullup,
  input wire [NPINS-1:0] o_pin_inbuf_en
);
  reg  [NPINS-1:0] func_q, dir_q;
  wire             lp = i_idle | i_powerdown | i_standby | i_hold;
  always @(posedge i_clk or negedge i_resetn)
    if (!i_resetn) begin
      func_q <= `UAP_RST_FUNC;
      dir_q  <= `UAP_RST_DIR;
    end else if (avs_write && avs_byteenable[0]) begin
      if (avs_address == `UAP_OFF_FUNC) func_q <= avs_writedata[NPINS-1:0];
      if (avs_address == `UAP_OFF_DIR) dir_q <= avs_writedata[NPINS-1:0];
    end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  sequence s_quiet; !avs_write [*3]; endsequence
  sequence s_fetch; i_cfg_fetch && !lp && func_q == '1; endsequence
  property p_rst; @(posedge i_clk) disable iff (1'b0)
    !i_resetn |-> o_pin_weak_pullup == '1 && o_pin_oe == '0; endproperty
  a_rst: assert property (p_rst) else $error("pins not weakly held in reset");
  property p_fetch; s_fetch |-> ##[1:3] o_pin == '1 && o_pin_oe == '1; endproperty
  a_fetch: assert property (p_fetch) else $error("fetch did not drive all ones");
  property p_float; (lp && !avs_write) [*3] |-> (o_pin_oe & func_q) == '0; endproperty
  a_float: assert property (p_float) else $error("address pin driven in low power");
  property p_keep; (lp && !avs_write) [*3] |-> (o_pin_oe | func_q | dir_q) == '1; endproperty
  a_keep: assert property (p_keep) else $error("push-pull pin released");
  property p_inbuf; s_quiet |-> o_pin_inbuf_en == (i_powerdown ? ~func_q : '1); endproperty
  a_inbuf: assert property (p_inbuf) else $error("input buffer enable wrong");
  property p_regf; i_data_access && !i_data_ext && i_data_regfile
    |-> o_access_internal && !o_access_offchip; endproperty
  a_regf: assert property (p_regf) else $error("register file access left chip");
  property p_ext; i_data_access && i_data_ext |-> o_access_page == i_data_page; endproperty
  a_ext: assert property (p_ext) else $error("extended page wrong");
  property p_under; i_data_access && i_data_ext && i_data_regfile
    |-> o_access_offchip && !o_access_internal; endproperty
  a_under: assert property (p_under) else $error("extended access kept internal");
endmodule // uap_props
bind uap_port uap_props #(.NPINS(NPINS)) u_props (.i_clk, .i_resetn, .avs_write,
  .i_cfg_fetch, .i_data_access, .i_data_ext, .i_data_regfile, .i_idle, .i_powerdown,
  .i_standby, .i_hold, .o_access_internal, .o_access_offchip, .avs_address,
  .avs_byteenable, .avs_writedata, .i_data_page, .o_access_page, .o_pin, .o_pin_oe,
  .o_pin_weak_pullup, .o_pin_inbuf_en);

// ===== dv/uap_ext_dev.sv
// Far side of the pins: board pull-ups and a device that may drive released lines.
// Assumes the bench enables the device only on lines the port has released.
`timescale 1ns/100ps
module uap_ext_dev (
  input  wire [3:0] i_drv,
  input  wire [3:0] i_oe,
  input  wire [3:0] i_ext_en,
  input  wire [3:0] i_ext_val,
  output wire [3:0] o_pad
);
  assign o_pad = (i_oe & i_drv) | (~i_oe & ((i_ext_en & i_ext_val) | ~i_ext_en));
endmodule // uap_ext_dev

// ===== dv/uap_port_test.sv
// Bench for the upper address port: Avalon tasks and pin checks.
// Assumes the external device model on the pins.
`timescale 1ns/100ps
`include "uap_defines.vh"
module uap_port_test;
  reg         i_clk = 0, i_resetn = 0, avs_read = 0, avs_write = 0, cfg = 0;
  reg         acc = 0, ext = 0, rf = 0, idle = 0, pd = 0, hold = 0;
  reg         cf = 0, stby = 0;
  reg  [3:0]  adr = 0, dpg = 0, ext_en = 0, ext_val = 0, cpg = 0;
  reg  [31:0] wdata = 0;
  wire [31:0] rdata;
  wire        wait_r, a_int, a_off;
  wire [3:0]  a_pg, pin, drv, oe, ibe;
  integer     err_total = 0, check_count = 0, cyc = 0;
  uap_port uap_port_inst (.i_clk(i_clk), .i_resetn(i_resetn), .avs_address(adr),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(wdata),
    .avs_byteenable(4'hf), .avs_readdata(rdata), .avs_waitrequest(wait_r),
    .i_cfg_fetch(cfg), .i_code_fetch(cf), .i_code_page(cpg), .i_data_access(acc),
    .i_data_ext(ext), .i_data_page(dpg), .i_data_regfile(rf), .i_idle(idle),
    .i_powerdown(pd), .i_standby(stby), .i_hold(hold), .o_access_internal(a_int),
    .o_access_offchip(a_off), .o_access_page(a_pg), .i_pin(pin), .o_pin(drv),
    .o_pin_oe(oe), .o_pin_weak_pullup(), .o_pin_inbuf_en(ibe));
  uap_ext_dev uap_ext_dev_inst (.i_drv(drv), .i_oe(oe), .i_ext_en(ext_en),
    .i_ext_val(ext_val), .o_pad(pin));
  initial forever #5 i_clk = ~i_clk;
  task chk(input [31:0] got, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // Read compares against d; the request holds until waitrequest is seen low
  task bus(input w, input [3:0] a, input [3:0] d);
    begin
      @(posedge i_clk);
      {adr, wdata, avs_write, avs_read} <= {a, 28'h0, d, w, !w};
      @(posedge i_clk);
      while (wait_r !== 1'b0) @(posedge i_clk);
      {avs_write, avs_read} <= 2'b00;
      #1 if (!w) chk(rdata, {28'h0, d});
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge i_clk);
  endtask
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  always @(posedge i_clk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      err_total = err_total + 1;
      wrap_up;
    end
  end
  initial begin
    tick(10);
    i_resetn <= 1;
    bus(0, `UAP_OFF_FUNC, `UAP_RST_FUNC);
    bus(0, `UAP_OFF_DIR, `UAP_RST_DIR);
    bus(0, `UAP_OFF_OUT, `UAP_RST_OUT);
    bus(0, 4'h0, 4'h0);
    @(posedge i_clk) cfg <= 1;
    @(posedge i_clk) cfg <= 0;
    tick(4);
    #1 chk({drv, oe}, 8'hff);
    @(posedge i_clk) idle <= 1;
    tick(4);
    #1 chk(oe, 4'h0);
    bus(0, `UAP_OFF_STATUS, 4'h6);
    @(posedge i_clk) {idle, stby} <= 2'b01;
    tick(4);
    #1 chk(oe, 4'h0);
    @(posedge i_clk) {idle, stby} <= 2'b00;
    tick(4);
    #1 chk({drv, oe}, 8'hff);
    @(posedge i_clk) {acc, ext, dpg} <= {2'b11, 4'ha};
    #1 chk({a_off, a_pg}, 5'h1a);
    @(posedge i_clk) rf <= 1;
    #1 chk({a_int, a_off}, 2'b01);
    @(posedge i_clk) {acc, ext, rf} <= 3'b000;
    tick(5);
    #1 chk(drv, 4'ha);
    @(posedge i_clk) {cf, cpg} <= 5'h16;
    tick(2);
    #1 chk(drv, 4'h6);
    @(posedge i_clk) cf <= 0;
    bus(1, `UAP_OFF_OUT, 4'h5);
    @(posedge i_clk) {acc, rf} <= 2'b11;
    #1 chk({a_int, a_off}, 2'b10);
    @(posedge i_clk) rf <= 0;
    #1 chk({a_off, a_pg}, 5'h15);
    bus(1, `UAP_OFF_CTRL, 4'h1);
    #1 chk({a_off, a_pg}, 5'h10);
    @(posedge i_clk) acc <= 0;
    bus(1, `UAP_OFF_DIR, 4'hc);
    bus(1, `UAP_OFF_FUNC, 4'h0);
    bus(1, `UAP_OFF_OUT, 4'h5);
    @(posedge i_clk) {hold, ext_en, ext_val} <= {1'b1, 8'h44};
    tick(4);
    #1 chk({drv, oe}, 8'h1b);
    bus(0, `UAP_OFF_LEVEL, 4'h5);
    @(posedge i_clk) {hold, ext_en} <= 5'h00;
    bus(1, `UAP_OFF_OUT, 4'h0);
    bus(1, `UAP_OFF_FUNC, 4'h3);
    @(posedge i_clk) pd <= 1;
    tick(3);
    #1 chk(ibe, 4'hc);
    wrap_up;
  end
endmodule // uap_port_test
